// ### core/pmmc_cmd_bank.sv
// Pin level readback, margin code table and time stamp setup commands
//
// Operation
// RULE1: Pin readback returns count 2, two bytes
// RULE2: Pin word maps pins 1-9, reserved zero
// RULE3: Margin table command reads and writes codes
// RULE4: Host readback sends count 2, selector, length
// RULE5: Readback: count, parameter, up to 16 codes
// RULE6: Host write: count, selector, parameter, codes
// RULE7: Code index picks stored code for converter
// RULE8: Range field selects five output ranges
// RULE9: Parameter bit 0 enables the converter
// RULE10: Time stamp setup is writable and readable
// RULE11: Bit 1 enables stamping; upper bits reserved
// RULE12: Bit 0 enables the crystal oscillator
`timescale 1ns/100ps
module pmmc_cmd_bank #(
  parameter int NUM_CONV = 9,
  parameter int NUM_CODES = 16
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire pmmc_pkg::pmmc_req_t req,
  output logic [7:0] rdByte,
  input wire logic [8:0] pinLevel,
  output logic [NUM_CONV-1:0][7:0] convCode,
  output logic [NUM_CONV-1:0][2:0] convRange,
  output logic [NUM_CONV-1:0] convEnable,
  output logic rtsEnable,
  output logic crystalOscOn
);
  logic [7:0] cmdQ, cmdD;
  logic [4:0] wrIdxQ, wrIdxD, rdIdxQ, rdIdxD;
  logic [7:0] cntQ, cntD, reqLenQ, reqLenD;
  logic [3:0] selQ, selD;
  logic [15:0] pinSnapQ, pinSnapD;
  logic [7:0] rdByteQ, rdByteD;
  logic [1:0] stampQ, stampD;
  pmmc_pkg::pmmc_param_t paramQ [NUM_CONV];
  pmmc_pkg::pmmc_param_t paramD [NUM_CONV];
  logic [7:0] tableQ [NUM_CONV][NUM_CODES];
  logic [7:0] tableD [NUM_CONV][NUM_CODES];
  logic [NUM_CONV-1:0][7:0] convCodeQ, convCodeD;
  logic selOk;
  logic [3:0] selIdx;
  logic [7:0] lenRet;
  logic [15:0] pinWord;
  logic [4:0] wrCode, rdCode;
  pmmc_pkg::pmmc_param_t newParam;

  // Pin word, reserved bits held at zero
  assign pinWord = {4'h0, pinLevel[6:3], pinLevel[8], pinLevel[7], // RULE2
                    3'h0, pinLevel[2:0]};
  assign selOk = selQ < 4'(NUM_CONV);
  assign selIdx = selOk ? selQ : 4'h0;
  // Host may ask for more than exists; answer is capped
  assign lenRet = (reqLenQ > pmmc_pkg::MARGIN_RD_MAX_COUNT) ?
                  pmmc_pkg::MARGIN_RD_MAX_COUNT : reqLenQ;
  assign wrCode = wrIdxQ - pmmc_pkg::MARGIN_WR_CODE_FIRST;
  assign rdCode = rdIdxQ - pmmc_pkg::MARGIN_RD_CODE_FIRST;
  assign newParam = pmmc_pkg::pmmc_param_t'(req.wrByte);

  // Command framing, write decode and read byte selection
  always_comb begin
    cmdD = cmdQ;
    wrIdxD = wrIdxQ;
    rdIdxD = rdIdxQ;
    cntD = cntQ;
    reqLenD = reqLenQ;
    selD = selQ;
    pinSnapD = pinSnapQ;
    rdByteD = rdByteQ;
    stampD = stampQ;
    paramD = paramQ;
    tableD = tableQ;
    if (req.start) begin
      cmdD = req.code;
      wrIdxD = 5'h00;
      rdIdxD = 5'h00;
    end else if (req.wrStb) begin
      if (wrIdxQ != 5'h1f) wrIdxD = wrIdxQ + 5'h01;
      if (cmdQ == pmmc_pkg::CMD_MARGIN_CODE) begin // RULE3
        case (wrIdxQ)
          5'h00: cntD = req.wrByte;
          5'h01: selD = req.wrByte[3:0];
          5'h02: begin
            // Count of 2 is the readback setup of a write-read
            if (cntQ == pmmc_pkg::MARGIN_RD_PARAM_COUNT) begin
              reqLenD = req.wrByte;
            end else if (selOk && newParam.range <= pmmc_pkg::RANGE_MAX) begin
              paramD[selIdx] = newParam; // RULE8
            end
          end
          default: begin
            if (selOk && cntQ != pmmc_pkg::MARGIN_RD_PARAM_COUNT &&
                wrCode < 5'(NUM_CODES) && {3'h0, wrIdxQ} <= cntQ) begin
              tableD[selIdx][wrCode[3:0]] = req.wrByte;
            end
          end
        endcase
      end else if (cmdQ == pmmc_pkg::CMD_TIME_STAMP &&
                   wrIdxQ == 5'h00) begin
        stampD = req.wrByte[1:0]; // RULE10 RULE11 RULE12
      end
    end else if (req.rdStb) begin
      if (rdIdxQ != 5'h1f) rdIdxD = rdIdxQ + 5'h01;
      rdByteD = 8'h00;
      case (cmdQ)
        pmmc_pkg::CMD_PIN_LEVEL: begin
          // Snapshot so both bytes come from one sample
          if (rdIdxQ == 5'h00) begin
            pinSnapD = pinWord;
            rdByteD = pmmc_pkg::PIN_BYTE_COUNT; // RULE1
          end else if (rdIdxQ == 5'h01) begin
            rdByteD = pinSnapQ[7:0];
          end else if (rdIdxQ == 5'h02) begin
            rdByteD = pinSnapQ[15:8];
          end
        end
        pmmc_pkg::CMD_MARGIN_CODE: begin
          if (rdIdxQ == 5'h00) begin
            rdByteD = lenRet; // RULE5
          end else if (rdIdxQ == 5'h01) begin
            rdByteD = paramQ[selIdx];
          end else if (rdCode < 5'(NUM_CODES) &&
                       {3'h0, rdIdxQ} <= lenRet) begin
            rdByteD = tableQ[selIdx][rdCode[3:0]];
          end
        end
        pmmc_pkg::CMD_TIME_STAMP: begin
          if (rdIdxQ == 5'h00) rdByteD = {6'h00, stampQ}; // RULE10
        end
        default: rdByteD = 8'h00;
      endcase
    end
  end

  // Register the command state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmdQ <= 8'h00;
      wrIdxQ <= 5'h00;
      rdIdxQ <= 5'h00;
      cntQ <= 8'h00;
      reqLenQ <= 8'h00;
      selQ <= 4'h0;
      pinSnapQ <= 16'h0000;
      rdByteQ <= 8'h00;
      stampQ <= pmmc_pkg::STAMP_RESET;
      for (int i = 0; i < NUM_CONV; i++) begin
        paramQ[i] <= pmmc_pkg::PARAM_RESET;
        for (int k = 0; k < NUM_CODES; k++) begin
          tableQ[i][k] <= pmmc_pkg::CODE_RESET;
        end
      end
    end else if (clkEn) begin
      cmdQ <= cmdD;
      wrIdxQ <= wrIdxD;
      rdIdxQ <= rdIdxD;
      cntQ <= cntD;
      reqLenQ <= reqLenD;
      selQ <= selD;
      pinSnapQ <= pinSnapD;
      rdByteQ <= rdByteD;
      stampQ <= stampD;
      paramQ <= paramD;
      tableQ <= tableD;
    end
  end

  // Code chosen by each converter's index
  always_comb begin
    for (int i = 0; i < NUM_CONV; i++) begin
      convCodeD[i] = tableQ[i][paramQ[i].codeIdx]; // RULE7
    end
  end

  // Converter code register, one cycle behind the table
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      convCodeQ <= '0;
    end else if (clkEn) begin
      convCodeQ <= convCodeD;
    end
  end

  // Converter controls straight from the parameter flops
  always_comb begin
    for (int i = 0; i < NUM_CONV; i++) begin
      convRange[i] = paramQ[i].range; // RULE8
      convEnable[i] = paramQ[i].enable; // RULE9
    end
  end

  assign convCode = convCodeQ;
  assign rdByte = rdByteQ;
  assign rtsEnable = stampQ[pmmc_pkg::STAMP_RTS_BIT]; // RULE11
  assign crystalOscOn = stampQ[pmmc_pkg::STAMP_XTAL_BIT]; // RULE12

  // Checks on the answers and the controls
  property p_pinCount;
    @(posedge clk_sys) disable iff (!arst_n)
    clkEn && req.rdStb && !req.start && cmdQ == pmmc_pkg::CMD_PIN_LEVEL &&
    rdIdxQ == 5'h00 |=> rdByte == 8'h02;
  endproperty
  a_pinCount: assert property (p_pinCount) else $error("pin count"); // RULE1
  property p_pinRsvd;
    @(posedge clk_sys) disable iff (!arst_n)
    clkEn && req.rdStb && !req.start && cmdQ == pmmc_pkg::CMD_PIN_LEVEL &&
    rdIdxQ == 5'h01 |=> rdByte[5:3] == 3'h0 && rdByte[7:6] ==
    $past(pinSnapQ[7:6]);
  endproperty
  a_pinRsvd: assert property (p_pinRsvd) else $error("pin map"); // RULE2
  property p_tableWrite;
    @(posedge clk_sys) disable iff (!arst_n)
    clkEn && req.wrStb && !req.start && cmdQ == pmmc_pkg::CMD_MARGIN_CODE &&
    wrIdxQ == 5'h03 && selQ == 4'h0 && cntQ >= 8'h03
    |=> tableQ[0][0] == $past(req.wrByte);
  endproperty
  a_tableWrite: assert property (p_tableWrite) // RULE3
    else $error("code store");
  property p_marginLen;
    @(posedge clk_sys) disable iff (!arst_n)
    clkEn && req.rdStb && !req.start && cmdQ == pmmc_pkg::CMD_MARGIN_CODE &&
    rdIdxQ == 5'h00 |=> rdByte <= 8'h11;
  endproperty
  a_marginLen: assert property (p_marginLen) else $error("length"); // RULE5
  property p_codeSel;
    @(posedge clk_sys) disable iff (!arst_n)
    // Code register follows the table one enabled edge later
    clkEn |=> convCode[0] == $past(tableQ[0][paramQ[0].codeIdx]);
  endproperty
  a_codeSel: assert property (p_codeSel) else $error("code pick"); // RULE7
  property p_range;
    @(posedge clk_sys) disable iff (!arst_n)
    convRange[0] <= 3'h4 && convRange[8] <= 3'h4;
  endproperty
  a_range: assert property (p_range) else $error("range"); // RULE8
  property p_enable;
    @(posedge clk_sys) disable iff (!arst_n)
    clkEn && req.wrStb && !req.start && cmdQ == pmmc_pkg::CMD_MARGIN_CODE &&
    wrIdxQ == 5'h02 && selQ == 4'h0 && cntQ != 8'h02 && req.wrByte[3:1] <= 3'h4
    |=> convEnable[0] == $past(req.wrByte[0]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable"); // RULE9
  property p_stampRead;
    @(posedge clk_sys) disable iff (!arst_n)
    clkEn && req.rdStb && !req.start && cmdQ == pmmc_pkg::CMD_TIME_STAMP &&
    rdIdxQ inside {5'h00, 5'h01} |=> rdByte[7:2] == 6'h00 &&
    rdByte[1:0] == ($past(rdIdxQ) == 5'h00 ? {rtsEnable, crystalOscOn} : 2'h0);
  endproperty
  a_stampRead: assert property (p_stampRead) // RULE10 RULE11
    else $error("stamp read");
  property p_stampWrite;
    @(posedge clk_sys) disable iff (!arst_n)
    clkEn && req.wrStb && !req.start && cmdQ == pmmc_pkg::CMD_TIME_STAMP &&
    wrIdxQ == 5'h00 |=> crystalOscOn == $past(req.wrByte[0]) &&
    rtsEnable == $past(req.wrByte[1]);
  endproperty
  a_stampWrite: assert property (p_stampWrite) // RULE12
    else $error("stamp write");
  c_pinRead: cover property (@(posedge clk_sys)
    clkEn && req.rdStb && cmdQ == pmmc_pkg::CMD_PIN_LEVEL && rdIdxQ == 5'h02);
  c_codeWrite: cover property (@(posedge clk_sys)
    clkEn && req.wrStb && cmdQ == pmmc_pkg::CMD_MARGIN_CODE && wrIdxQ == 5'h12);
  c_codeRead: cover property (@(posedge clk_sys)
    clkEn && req.rdStb && cmdQ == pmmc_pkg::CMD_MARGIN_CODE && rdIdxQ == 5'h11);
  c_stamp: cover property (@(posedge clk_sys) rtsEnable && crystalOscOn);
endmodule : pmmc_cmd_bank

// ### core/pmmc_pkg.sv
// Constants and types for the pin, margin code and time stamp commands
package pmmc_pkg;
  localparam logic [7:0] CMD_PIN_LEVEL = 8'hea;
  localparam logic [7:0] CMD_MARGIN_CODE = 8'heb;
  localparam logic [7:0] CMD_TIME_STAMP = 8'hec;
  localparam logic [7:0] PIN_BYTE_COUNT = 8'h02;
  localparam logic [7:0] MARGIN_RD_PARAM_COUNT = 8'h02;
  localparam logic [7:0] MARGIN_RD_MAX_COUNT = 8'h11;
  localparam logic [4:0] MARGIN_WR_CODE_FIRST = 5'h03;
  localparam logic [4:0] MARGIN_RD_CODE_FIRST = 5'h02;
  localparam logic [2:0] RANGE_MAX = 3'h4;
  localparam int STAMP_RTS_BIT = 1;
  localparam int STAMP_XTAL_BIT = 0;
  localparam logic [1:0] STAMP_RESET = 2'h0;
  localparam logic [7:0] CODE_RESET = 8'h00;

  // Code parameter byte layout
  typedef struct packed {
    logic [3:0] codeIdx;
    logic [2:0] range;
    logic enable;
  } pmmc_param_t;

  localparam pmmc_param_t PARAM_RESET = '0;

  // Byte-level command port from the bus transaction layer
  typedef struct packed {
    logic start;
    logic [7:0] code;
    logic wrStb;
    logic [7:0] wrByte;
    logic rdStb;
  } pmmc_req_t;
endpackage : pmmc_pkg

// ### verification/pmbus_mfr_pin_margin_rts_cmds_tb.sv
// Self-checking bench for the pin, margin code and stamp commands
`timescale 1ns/100ps
module pmbus_mfr_pin_margin_rts_cmds_tb;
  typedef struct {
    logic [7:0] code;
    logic [8:0] pins;
    int nw;
    logic [39:0] w;
    int nr;
    logic [31:0] e;
  } pmmc_row_t;

  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [8:0] pinLevel = '0;
  pmmc_pkg::pmmc_req_t req;
  logic [7:0] rdByte;
  logic [8:0][7:0] convCode;
  logic [8:0][2:0] convRange;
  logic [8:0] convEnable;
  logic rtsEnable;
  logic crystalOscOn;
  int badCount = 0;
  int nTests = 0;
  pmmc_row_t rows[14];

  always #4 clk_sys = ~clk_sys;

  pmmc_host_model pmmc_host_model_inst (.clk_sys(clk_sys), .req(req));

  pmmc_cmd_bank pmmc_cmd_bank_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .req(req),
    .rdByte(rdByte), .pinLevel(pinLevel), .convCode(convCode),
    .convRange(convRange), .convEnable(convEnable),
    .rtsEnable(rtsEnable), .crystalOscOn(crystalOscOn));

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic endOfTest;
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : endOfTest

  // Watchdog sized well above the expected few hundred cycles
  initial begin
    #(8 * 5000);
    badCount++;
    endOfTest();
  end

  // Rows: command, pin levels, written bytes, expected read bytes
  initial begin
    rows = '{
      '{8'hec, 9'h0, 1, 40'hff, 0, 32'h0},
      '{8'hec, 9'h0, 0, 40'h0, 2, 32'h0003},
      '{8'hea, 9'h1ad, 0, 40'h0, 4, 32'h0005c502},
      '{8'hea, 9'h052, 0, 40'h0, 3, 32'h0a0202},
      '{8'heb, 9'h0, 4, 40'h55090004, 0, 32'h0},
      '{8'heb, 9'h0, 3, 40'h030002, 3, 32'h550903},
      '{8'heb, 9'h0, 3, 40'h0b0003, 0, 32'h0},
      '{8'heb, 9'h0, 3, 40'h200002, 3, 32'h550911},
      '{8'hed, 9'h0, 0, 40'h0, 1, 32'h0},
      '{8'heb, 9'h0, 5, 40'h2211130805, 0, 32'h0},
      // Code byte past the count is dropped, code 1 keeps its value
      '{8'heb, 9'h0, 5, 40'h8877130803, 0, 32'h0},
      // Selector 9 is out of range: nothing may land on any converter
      '{8'heb, 9'h0, 4, 40'h66070904, 0, 32'h0},
      '{8'heb, 9'h0, 3, 40'h040802, 4, 32'h22771304},
      '{8'hec, 9'h0, 1, 40'h02, 0, 32'h0}};
    repeat (16) @(negedge clk_sys);
    arst_n = 1'b1;
    chk("rtsRst", {7'h0, rtsEnable}, 8'h00);
    foreach (rows[i]) begin
      pinLevel = rows[i].pins;
      pmmc_host_model_inst.put(1'b1, 1'b0, 1'b0, rows[i].code);
      for (int j = 0; j < rows[i].nw; j++) begin
        pmmc_host_model_inst.put(1'b0, 1'b1, 1'b0, rows[i].w[j*8+:8]);
      end
      for (int j = 0; j < rows[i].nr; j++) begin
        pmmc_host_model_inst.put(1'b0, 1'b0, 1'b1, 8'h00);
        @(negedge clk_sys);
        chk("rdByte", rdByte, rows[i].e[j*8+:8]);
      end
    end
    @(negedge clk_sys);
    chk("code9", convCode[8], 8'h22);
    chk("range9", {5'h0, convRange[8]}, 8'h01);
    chk("en9", {7'h0, convEnable[8]}, 8'h01);
    chk("code1", convCode[0], 8'h55);
    chk("range1", {5'h0, convRange[0]}, 8'h04);
    chk("rts", {7'h0, rtsEnable}, 8'h01);
    chk("xtal", {7'h0, crystalOscOn}, 8'h00);
    // Every legal range on converter 2, with the converter disabled
    for (int r = 0; r < 5; r++) begin
      pmmc_host_model_inst.put(1'b1, 1'b0, 1'b0, 8'heb);
      pmmc_host_model_inst.put(1'b0, 1'b1, 1'b0, 8'h03);
      pmmc_host_model_inst.put(1'b0, 1'b1, 1'b0, 8'h01);
      pmmc_host_model_inst.put(1'b0, 1'b1, 1'b0, {4'h0, 3'(r), 1'b0});
      @(negedge clk_sys);
      chk("range2", {5'h0, convRange[1]}, 8'(r));
      chk("en2", {7'h0, convEnable[1]}, 8'h00);
    end
    // Frozen clock enable must drop a stamp write
    clkEn = 1'b0;
    pmmc_host_model_inst.put(1'b1, 1'b0, 1'b0, 8'hec);
    pmmc_host_model_inst.put(1'b0, 1'b1, 1'b0, 8'h01);
    clkEn = 1'b1;
    chk("xtalHeld", {7'h0, crystalOscOn}, 8'h00);
    // Reset in mid-run clears the converter 1 enable and rtsEnable
    arst_n = 1'b0;
    @(negedge clk_sys);
    arst_n = 1'b1;
    chk("enRst", {7'h0, convEnable[0]}, 8'h00);
    chk("rtsRst2", {7'h0, rtsEnable}, 8'h00);
    endOfTest();
  end
endmodule : pmbus_mfr_pin_margin_rts_cmds_tb

// ### verification/pmmc_host_model.sv
// Host model that drives the byte-level command port
`timescale 1ns/100ps
module pmmc_host_model (
  input wire logic clk_sys,
  output pmmc_pkg::pmmc_req_t req
);
  initial req = '0;

  // One strobe per call: set at a falling edge, held one full cycle
  // Byte order and counts come from the caller's rows
  task automatic put(input logic st, input logic wr, input logic rd,
                     input logic [7:0] val);
    @(negedge clk_sys);
    req.start = st;
    req.wrStb = wr;
    req.rdStb = rd;
    if (st) req.code = val;
    if (wr) req.wrByte = val;
    @(negedge clk_sys);
    req.start = 1'b0;
    req.wrStb = 1'b0;
    req.rdStb = 1'b0;
    // Released data must not look like a valid byte
    req.wrByte = ~req.wrByte;
  endtask : put
endmodule : pmmc_host_model
